// >>> rtl/flash_cmd.v
// Purpose: Decodes remote write, erase-then-write and read commands and answers each one.
// Assumes: Request bytes arrive on a valid/ready stream marked by a last flag; source endpoint given beside it.
// Notes: Registers over AXI4-Lite give event status, mask, state and an enable.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.vh"
// Function
// - Each accepted request gets exactly one response, sent to its source endpoint.
// - Write answers with code 0x82, erase-then-write with 0x83.
// - Status bit zero is one on failure, zero on success; others zero.
// - Block and offset fields of the response echo the request.
// - Write responses carry byte count zero and no payload.
// - Code 0x04 is decoded as a read of flash contents.
// - Offset field is the byte position in the block where access starts.
// - A read is answered with code 0x84.
// - Read response appends bytes in address order with count of appended bytes.
// - Erase-then-write erases the block first, or the whole store when its count is zero; plain write erases only when its count is zero.
// - Write request with count zero erases the whole store, writes nothing.
module flash_cmd #(
  parameter BLOCKS = 4,
  parameter BLOCK_BYTES = 16,
  parameter AW = 6,
  parameter EPW = 8
) (
  // Clock and reset.
  input wire mclk,
  input wire rst,
  // Request byte stream.
  input wire req_valid,
  input wire [7:0] req_data,
  input wire req_last,
  input wire [EPW-1:0] req_src_ep,
  output wire req_ready,
  // Response byte stream.
  output reg rsp_valid,
  output reg [7:0] rsp_data,
  output reg rsp_last,
  output reg [EPW-1:0] rsp_dst_ep,
  input wire rsp_ready,
  // AXI4-Lite slave.
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Interrupt.
  output wire irq
);
  localparam [5:0] ST_HDR = 6'h01;
  localparam [5:0] ST_DATA = 6'h02;
  localparam [5:0] ST_DRAIN = 6'h04;
  localparam [5:0] ST_HEAD = 6'h08;
  localparam [5:0] ST_RDATA = 6'h10;
  localparam [5:0] ST_WAIT = 6'h20;

  reg [5:0] state;
  reg [3:0] hcnt;
  reg [7:0] code;
  reg [15:0] blk;
  reg [15:0] ofs;
  reg [15:0] cnt;
  reg [15:0] dcnt;
  reg [15:0] pos;
  reg fail;
  reg [2:0] status;
  reg [2:0] mask;
  reg enable;
  reg [AW-1:0] addr;
  reg wr_en;
  reg [7:0] wr_data;
  reg erase_block;
  reg erase_all;
  reg [AW-1:0] erase_base;
  wire [7:0] rd_data;
  reg aw_hold;
  reg w_hold;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg req_valid_seen_last;

  flash_store #(.BLOCKS(BLOCKS), .BLOCK_BYTES(BLOCK_BYTES), .AW(AW)) store (
    .mclk(mclk),
    .rst(rst),
    .addr(addr),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .erase_block(erase_block),
    .erase_all(erase_all),
    .erase_base(erase_base),
    .rd_data(rd_data)
  );

  // Header checks: write and read codes, block in range, access within one block.
  wire is_write = (code == `CODE_WRITE) || (code == `CODE_ERASE_WRITE);
  wire is_read = (code == `CODE_READ);
  wire blk_bad = (blk > `LAST_BLOCK) || (blk >= BLOCKS);
  wire span_bad = ({16'h0000, ofs} + {16'h0000, cnt}) > BLOCK_BYTES;
  wire hdr_bad = !(is_write || is_read) || blk_bad || span_bad;
  wire hdr_err = hdr_bad || (hcnt != 4'h0);
  localparam [AW-1:0] BLOCK_STEP = BLOCK_BYTES;
  wire [AW-1:0] base = blk[AW-1:0] * BLOCK_STEP;
  wire hdr_last_byte = (hcnt == `HDR_BYTES - 4'h1);
  wire req_fire = req_valid && req_ready;

  assign req_ready = enable && (state == ST_HDR || state == ST_DATA || state == ST_DRAIN);

  // Response header byte for position pos.
  reg [7:0] hdr_byte;
  always @* begin
    case (pos[2:0])
      3'd0: hdr_byte = code | `RESP_FLAG;
      3'd1: hdr_byte = {7'h00, fail};
      3'd2: hdr_byte = blk[15:8];
      3'd3: hdr_byte = blk[7:0];
      3'd4: hdr_byte = ofs[15:8];
      3'd5: hdr_byte = ofs[7:0];
      3'd6: hdr_byte = (is_read && !fail) ? cnt[15:8] : 8'h00;
      default: hdr_byte = (is_read && !fail) ? cnt[7:0] : 8'h00;
    endcase
  end

  wire rsp_take = rsp_valid && rsp_ready;
  reg rd_pending;
  wire rsp_last_sent = (state == ST_RDATA) && (dcnt == cnt) && !rsp_valid;

  always @(posedge mclk) begin
    wr_en <= 1'b0;
    erase_block <= 1'b0;
    erase_all <= 1'b0;
    if (rst) begin
      state <= ST_HDR;
      hcnt <= 4'h0;
      code <= 8'h00;
      blk <= 16'h0000;
      ofs <= 16'h0000;
      cnt <= 16'h0000;
      dcnt <= 16'h0000;
      pos <= 16'h0000;
      fail <= 1'b0;
      addr <= {AW{1'b0}};
      wr_data <= 8'h00;
      erase_base <= {AW{1'b0}};
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_last <= 1'b0;
      rsp_dst_ep <= {EPW{1'b0}};
      rd_pending <= 1'b0;
    end else begin
      case (state)
        ST_HDR: begin
          if (req_fire) begin
            // Big-endian header fields in fixed order.
            case (hcnt)
              4'h0: code <= req_data;
              4'h2: blk[15:8] <= req_data;
              4'h3: blk[7:0] <= req_data;
              4'h4: ofs[15:8] <= req_data;
              4'h5: ofs[7:0] <= req_data;
              4'h6: cnt[15:8] <= req_data;
              4'h7: cnt[7:0] <= req_data;
              default: hcnt <= hcnt;
            endcase
            hcnt <= hcnt + 4'h1;
            if (hcnt == 4'h0) begin
              rsp_dst_ep <= req_src_ep;
            end
            if (hdr_last_byte) begin
              hcnt <= 4'h0;
              state <= ST_WAIT;
            end else if (req_last) begin
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // Header complete: decide, erase if asked, then either take data or answer.
          fail <= hdr_err;
          dcnt <= 16'h0000;
          addr <= base + ofs[AW-1:0];
          pos <= 16'h0000;
          if (!hdr_err && is_write && cnt == 16'h0000) begin
            erase_all <= 1'b1;
          end else if (!hdr_err && code == `CODE_ERASE_WRITE) begin
            erase_block <= 1'b1;
            erase_base <= base;
          end
          if (!req_valid_seen_last) begin
            state <= (is_write && !hdr_err && cnt != 16'h0000) ? ST_DATA : ST_DRAIN;
          end else begin
            state <= ST_HEAD;
          end
        end
        ST_DATA: begin
          if (req_fire) begin
            if (dcnt < cnt) begin
              wr_en <= 1'b1;
              wr_data <= req_data;
              dcnt <= dcnt + 16'h0001;
            end
            if (wr_en) begin
              addr <= addr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (req_last) begin
              state <= ST_HEAD;
            end
          end else if (wr_en) begin
            addr <= addr + {{(AW-1){1'b0}}, 1'b1};
          end
        end
        ST_DRAIN: begin
          if (req_fire && req_last) begin
            state <= ST_HEAD;
          end
        end
        ST_HEAD: begin
          // One response per request, header first.
          // All write data has been counted by the first header byte.
          if (is_write && pos == 16'h0000) begin
            fail <= fail || (dcnt != cnt);
          end
          if (!rsp_valid || rsp_take) begin
            if (pos == {12'h000, `HDR_BYTES}) begin
              rsp_valid <= 1'b0;
              rsp_last <= 1'b0;
              addr <= base + ofs[AW-1:0];
              dcnt <= 16'h0000;
              rd_pending <= 1'b0;
              state <= ST_RDATA;
            end else begin
              rsp_valid <= 1'b1;
              rsp_data <= hdr_byte;
              rsp_last <= (pos == 16'h0007) && !(is_read && !fail && cnt != 16'h0000);
              pos <= pos + 16'h0001;
            end
          end
        end
        ST_RDATA: begin
          // Read payload in address order; a one-cycle store latency is tracked.
          if (rsp_take) begin
            rsp_valid <= 1'b0;
          end
          if (!rsp_last_sent && is_read && !fail && dcnt < cnt) begin
            if (!rd_pending && (!rsp_valid || rsp_take)) begin
              rd_pending <= 1'b1;
            end else if (rd_pending) begin
              rsp_valid <= 1'b1;
              rsp_data <= rd_data;
              rsp_last <= (dcnt == cnt - 16'h0001);
              dcnt <= dcnt + 16'h0001;
              addr <= addr + {{(AW-1){1'b0}}, 1'b1};
              rd_pending <= 1'b0;
            end
          end else if (!rsp_valid || rsp_take) begin
            rsp_valid <= 1'b0;
            rsp_last <= 1'b0;
            hcnt <= 4'h0;
            state <= ST_HDR;
          end
        end
        default: state <= ST_HDR;
      endcase
    end
  end

  // Tracks whether the request frame already ended inside its header.
  always @(posedge mclk) begin
    if (rst) begin
      req_valid_seen_last <= 1'b0;
    end else if (state == ST_HDR && req_fire) begin
      req_valid_seen_last <= req_last;
    end
  end

  // Events: response done, error reported, whole store erased.
  wire next_leave = !(is_read && !fail && dcnt < cnt) && (!rsp_valid || rsp_take);
  wire ev_done = (state == ST_RDATA) && (next_leave);
  wire [2:0] events = {erase_all, ev_done && fail, ev_done};

  // AXI4-Lite slave: address and data taken in either order.
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire aw_ok = aw_hold || s_axi_awvalid;
  wire w_ok = w_hold || s_axi_wvalid;
  wire [11:0] wa = aw_hold ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_hold ? w_data : s_axi_wdata;
  wire [3:0] ws = w_hold ? w_strb : s_axi_wstrb;
  wire do_write = aw_ok && w_ok && !s_axi_bvalid;
  wire wr_map = (wa == `OFS_STATUS) || (wa == `OFS_MASK) || (wa == `OFS_STATE) || (wa == `OFS_CTRL);
  wire [2:0] clr = (do_write && wa == `OFS_STATUS && ws[0]) ? wd[2:0] : 3'h0;

  always @(posedge mclk) begin
    if (rst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h00000000;
      status <= 3'h0;
      mask <= `MASK_RESET;
      enable <= `CTRL_RESET;
    end else begin
      // A new event wins over a clear in the same cycle.
      status <= (status & ~clr) | events;
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? 2'b00 : 2'b10;
        if (wa == `OFS_MASK && ws[0]) begin
          mask <= wd[2:0];
        end
        if (wa == `OFS_CTRL && ws[0]) begin
          enable <= wd[0];
        end
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `OFS_STATUS: s_axi_rdata <= {29'h0, status};
          `OFS_MASK: s_axi_rdata <= {29'h0, mask};
          `OFS_STATE: s_axi_rdata <= {26'h0, state};
          `OFS_CTRL: s_axi_rdata <= {31'h0, enable};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign irq = |(status & mask);
endmodule
`default_nettype wire

// >>> rtl/flash_cmd_regs.vh
// Purpose: Constants for the remote flash command handler.
// Assumes: Byte-wide request and response streams, 32-bit register words.
// Notes: Offsets are byte addresses on the register bus.
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH
`define CODE_WRITE 8'h02
`define CODE_ERASE_WRITE 8'h03
`define CODE_READ 8'h04
`define RESP_FLAG 8'h80
`define STATUS_FAIL_BIT 0
`define LAST_BLOCK 16'h009f
`define HDR_BYTES 4'h8
`define OFS_STATUS 12'h000
`define OFS_MASK 12'h004
`define OFS_STATE 12'h008
`define OFS_CTRL 12'h00c
`define EV_DONE 0
`define EV_ERROR 1
`define EV_ERASE_ALL 2
`define MASK_RESET 3'h0
`define CTRL_RESET 1'h1
`endif

// >>> rtl/flash_store.v
// Purpose: Flip-flop model of the general flash store with block and whole-store erase.
// Assumes: Erased bytes read as all ones.
// Notes: Erase of one block or of the whole store completes in one cycle.
`timescale 1ns/1ps
`default_nettype none
module flash_store #(
  parameter BLOCKS = 4,
  parameter BLOCK_BYTES = 16,
  parameter AW = 6
) (
  // Clock and reset.
  input wire mclk,
  input wire rst,
  // Access port.
  input wire [AW-1:0] addr,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire erase_block,
  input wire erase_all,
  input wire [AW-1:0] erase_base,
  output reg [7:0] rd_data
);
  localparam DEPTH = BLOCKS * BLOCK_BYTES;
  reg [7:0] mem [0:DEPTH-1];
  integer i;
  always @(posedge mclk) begin
    rd_data <= (addr < DEPTH) ? mem[addr] : 8'hff;
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (rst || erase_all) begin
        mem[i] <= 8'hff;
      end else if (erase_block && i >= erase_base && i < erase_base + BLOCK_BYTES) begin
        mem[i] <= 8'hff;
      end else if (wr_en && addr == i) begin
        mem[i] <= mem[i] & wr_data;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/flash_cmd_properties.sv
// Purpose: Checker of the response stream of the flash command handler.
// Assumes: One request frame at a time, header taken before its response starts.
// Notes: Bound to flash_cmd below.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_checker #(
  parameter EPW = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic [EPW-1:0] rsp_dst_ep,
  input wire logic rsp_ready,
  input wire logic irq
);
  logic [7:0] qh [0:7];
  logic [3:0] qidx;
  logic [5:0] ridx;
  logic [7:0] rcode;
  logic rok;
  wire [15:0] qcnt = {qh[6], qh[7]};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Keeps the request header and the position inside the response.
  always @(posedge mclk) begin
    if (rst) begin
      qidx <= 4'h0;
      ridx <= 6'h00;
    end else begin
      if (req_valid && req_ready) begin
        if (qidx < 4'h8) qh[qidx[2:0]] <= req_data;
        qidx <= req_last ? 4'h0 : (qidx == 4'h8 ? qidx : qidx + 4'h1);
      end
      if (rsp_valid && rsp_ready) begin
        ridx <= rsp_last ? 6'h00 : ridx + 6'h01;
        if (ridx == 6'h00) rcode <= rsp_data;
        if (ridx == 6'h01) rok <= ~rsp_data[0];
      end
    end
  end
  a_rsp_held: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last))
    else $error("response byte changed before it was taken");
  a_ep_stable: assert property (rsp_valid && !(rsp_ready && rsp_last) |=> $stable(rsp_dst_ep))
    else $error("response endpoint changed inside a frame");
  a_busy_refuse: assert property (rsp_valid |-> !req_ready)
    else $error("request taken while responding");
  a_answer_soon: assert property (req_valid && req_ready && req_last |-> ##[1:10] rsp_valid)
    else $error("no response after request frame");
  a_code_ok: assert property (rsp_valid && ridx == 6'h00 |-> rsp_data == (qh[0] | 8'h80))
    else $error("response code does not match request");
  a_status_resv: assert property (rsp_valid && ridx == 6'h01 |-> rsp_data[7:1] == 7'h00)
    else $error("reserved status bits set");
  a_echo_fields: assert property (rsp_valid && ridx >= 6'h02 && ridx <= 6'h05 |-> rsp_data == qh[ridx[2:0]])
    else $error("block or offset not echoed");
  a_write_empty: assert property (rsp_valid && ridx >= 6'h06 && rcode != 8'h84 |->
    rsp_data == 8'h00 && rsp_last == (ridx == 6'h07))
    else $error("write response not empty");
  a_read_length: assert property (rsp_valid && rsp_last && rcode == 8'h84 |->
    ridx == (rok ? qcnt[5:0] + 6'h07 : 6'h07))
    else $error("read response length wrong");
  cover property (rsp_valid && rsp_ready && rsp_last && rcode == 8'h84 && rok);
  cover property (rsp_valid && !rsp_ready);
  cover property ($rose(irq));
endmodule
bind flash_cmd flash_cmd_checker #(.EPW(EPW)) chk_inst (.mclk(mclk), .rst(rst), .req_valid(req_valid),
  .req_data(req_data), .req_last(req_last), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_dst_ep(rsp_dst_ep), .rsp_ready(rsp_ready), .irq(irq));
`default_nettype wire

// >>> verif/remote_node.sv
// Purpose: Requesting node that sends command frames and collects responses.
// Assumes: Frames are built by the caller in field order.
// Notes: With slow set the response sink stalls every other cycle.
`timescale 1ns/1ps
`default_nettype none
module remote_node #(
  parameter EPW = 8
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Request side.
  output var logic req_valid,
  output var logic [7:0] req_data,
  output var logic req_last,
  output var logic [EPW-1:0] req_src_ep,
  input wire logic req_ready,
  // Response side.
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic [EPW-1:0] rsp_dst_ep,
  output var logic rsp_ready
);
  logic [7:0] rxq [$];
  logic [EPW-1:0] last_ep;
  logic slow;
  int nframes;
  initial begin
    req_valid = 1'b0;
    req_data = 8'h00;
    req_last = 1'b0;
    req_src_ep = '0;
    rsp_ready = 1'b0;
    slow = 1'b0;
    nframes = 0;
  end
  // Each byte stands until the edge that takes it; a released data line shows the inverse.
  task automatic send(input logic [7:0] f [$], input logic [EPW-1:0] ep);
    for (int i = 0; i < f.size(); i++) begin
      req_valid <= 1'b1;
      req_data <= f[i];
      req_last <= (i == f.size() - 1);
      req_src_ep <= ep;
      @(posedge mclk);
      while (req_ready !== 1'b1) @(posedge mclk);
    end
    req_valid <= 1'b0;
    req_last <= 1'b0;
    req_data <= ~f[f.size() - 1];
  endtask
  always @(posedge mclk) begin
    rsp_ready <= rst ? 1'b0 : (slow ? ~rsp_ready : 1'b1);
    if (!rst && rsp_valid && rsp_ready) begin
      rxq.push_back(rsp_data);
      if (rsp_last) begin
        last_ep <= rsp_dst_ep;
        nframes <= nframes + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: Self-checking bench of the flash command handler.
// Assumes: Four blocks of sixteen bytes; erased bytes read as all ones.
// Notes: Rows hold code, block, offset and count of one request.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.vh"
module tb_top;
  logic mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] rr;
  wire req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_ready, irq;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [7:0] req_data, rsp_data, req_src_ep, rsp_dst_ep;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] mem [0:63];
  logic [31:0] rows [0:12] = '{32'h02010004, 32'h04010006, 32'h02010203, 32'h03010502, 32'h04010010,
    32'h04030f02, 32'h02c80002, 32'h02020c04, 32'h02020e04, 32'h04020c04, 32'h02000000, 32'h04020c04,
    32'h07010002};
  flash_cmd #(.BLOCKS(4), .BLOCK_BYTES(16), .AW(6), .EPW(8)) flash_cmd_inst (.mclk(mclk), .rst(rst),
    .req_valid(req_valid), .req_data(req_data), .req_last(req_last), .req_src_ep(req_src_ep),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .rsp_dst_ep(rsp_dst_ep), .rsp_ready(rsp_ready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
  remote_node #(.EPW(8)) remote_node_inst (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_data(req_data), .req_last(req_last), .req_src_ep(req_src_ep), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_dst_ep(rsp_dst_ep),
    .rsp_ready(rsp_ready));
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] %s expected %h got %h", nm, ex, got);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge mclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge mclk);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic run_row(input logic [31:0] row, input logic [7:0] ep);
    logic [7:0] f [$];
    logic [7:0] e [$];
    logic [7:0] c, b, o, n, v;
    logic err;
    int k;
    {c, b, o, n} = row;
    err = (b > 8'h03) || (o + n > 16) || (c < 8'h02) || (c > 8'h04);
    f = {c, 8'h00, 8'h00, b, 8'h00, o, 8'h00, n};
    if (!err && c != `CODE_READ && n == 8'h00) for (k = 0; k < 64; k++) mem[k] = 8'hff;
    if (!err && c == `CODE_ERASE_WRITE) for (k = 0; k < 16; k++) mem[b * 16 + k] = 8'hff;
    for (k = 0; k < n && c != `CODE_READ; k++) begin
      v = 8'h3c ^ ep ^ k[7:0];
      f.push_back(v);
      if (!err) mem[b * 16 + o + k] = mem[b * 16 + o + k] & v;
    end
    e = {c | 8'h80, 8'(err), 8'h00, b, 8'h00, o, 8'h00, (c == `CODE_READ && !err) ? n : 8'h00};
    if (c == `CODE_READ && !err) for (k = 0; k < n; k++) e.push_back(mem[b * 16 + o + k]);
    remote_node_inst.rxq.delete();
    remote_node_inst.slow = ep[0];
    k = remote_node_inst.nframes;
    remote_node_inst.send(f, ep);
    repeat (300) if (remote_node_inst.nframes == k) @(posedge mclk);
    check("rsp_len", e.size(), remote_node_inst.rxq.size());
    for (k = 0; k < e.size() && k < remote_node_inst.rxq.size(); k++)
      check("rsp_byte", e[k], remote_node_inst.rxq[k]);
    check("rsp_ep", ep, remote_node_inst.last_ep);
    $display("request %h done", row);
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    for (int k = 0; k < 64; k++) mem[k] = 8'hff;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    axr(`OFS_MASK, d, rr);
    check("mask_rst", {29'h0, `MASK_RESET}, d);
    axr(`OFS_CTRL, d, rr);
    check("ctrl_rst", {31'h0, `CTRL_RESET}, d);
    axw(`OFS_CTRL, 32'h0, rr);
    check("ready_off", 32'h0, req_ready);
    axw(`OFS_CTRL, 32'h1, rr);
    check("bresp", 32'h0, rr);
    for (int i = 0; i < 13; i++) run_row(rows[i], 8'h40 + i[7:0]);
    axr(`OFS_STATUS, d, rr);
    check("status_ev", 32'h7, d);
    check("irq_masked", 32'h0, irq);
    axw(`OFS_MASK, 32'h1, rr);
    check("irq_on", 32'h1, irq);
    axw(`OFS_STATUS, 32'h1, rr);
    check("irq_clr", 32'h0, irq);
    axr(`OFS_STATUS, d, rr);
    check("status_w1c", 32'h6, d);
    axw(`OFS_MASK, 32'h6, rr);
    check("irq_err", 32'h1, irq);
    axw(`OFS_STATUS, 32'h6, rr);
    check("irq_off", 32'h0, irq);
    axr(12'h010, d, rr);
    check("unmapped_rresp", 32'h2, rr);
    check("unmapped_data", 32'h0, d);
    axw(12'h014, 32'h1, rr);
    check("unmapped_bresp", 32'h2, rr);
    s_axi_wstrb <= 4'h0;
    axw(`OFS_MASK, 32'h1, rr);
    s_axi_wstrb <= 4'hf;
    axr(`OFS_MASK, d, rr);
    check("mask_strb", 32'h6, d);
    $display("register test done");
    run_row(32'h02020c04, 8'h60);
    axw(`OFS_CTRL, 32'h0, rr);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check("ready_rst", 32'h1, req_ready);
    axr(`OFS_MASK, d, rr);
    check("mask_rst2", 32'h0, d);
    for (int k = 0; k < 64; k++) mem[k] = 8'hff;
    run_row(32'h04020c04, 8'h61);
    $display("reset test done");
    final_report();
  end
endmodule
`default_nettype wire
